// ==== printer_video_serializer.sv ====
// Printer video serializer: source select, two-entry buffer, margins, shifter.
// Assumes sync strobes and the pixel clock input are asynchronous pins.
//
// Contract
// RL1 - FIFO fed from one of three sources
// RL2 - One serial pixel bit per video clock
// RL3 - FIFO word loaded into shift register
// RL4 - PLL mode: clock aligned to line sync
// RL5 - Bypass mode: engine clock drives serializer
// RL6 - Video clock is input, or input/8
// RL7 - Shift order chosen by configuration bit
// RL8 - DMA address counts up or down
// RL9 - Vertical margin counts line syncs from page
// RL10 - Horizontal margin reloads per line, counts dots
// RL11 - Data starts first dot after margin
// RL12 - Inverse video inverts every output bit
// RL13 - Reset held over five video clocks
// RL14 - Sync pulses longer than one video clock
// RL15 - Line pixel count multiple of 32
// RL16 - Program margin as n minus one
// RL17 - Line interrupt on last word read
// RL18 - Band interrupt on last line's last word
// RL19 - Page interrupt while page sync asserted
// RL20 - Asynchronous inputs resynchronised before use
// RL21 - Idle output is inactive level, inverted
`timescale 1ns/1ps
module printer_video_serializer
	import video_pkg::*;
(
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// Engine pins
	input  wire logic                       pixel_clock_input,
	input  wire logic                       page_start_strobe_n,
	input  wire logic                       line_start_strobe_n,
	output logic                            video_out,
	// Configuration
	input  wire logic                       pll_mode,
	input  wire logic                       shift_order_select,
	input  wire logic                       dma_address_direction,
	input  wire logic                       invert_video_enable,
	input  wire logic [MARGIN_W-1:0]        top_margin_lines,
	input  wire logic [MARGIN_W-1:0]        left_margin_dots,
	input  wire logic [MARGIN_W-1:0]        words_per_line,
	input  wire logic [MARGIN_W-1:0]        lines_per_band,
	input  wire logic [video_pkg::ADDR_W-1:0] dma_start_addr,
	input  wire logic                       dma_addr_load,
	// Word sources
	input  wire logic [1:0]                 source_select,
	input  wire logic [WORD_W-1:0]          lossless_data,
	input  wire logic                       lossless_valid,
	output logic                            lossless_ready,
	input  wire logic [WORD_W-1:0]          alt_data,
	input  wire logic                       alt_valid,
	output logic                            alt_ready,
	input  wire logic [WORD_W-1:0]          mem_data,
	input  wire logic                       mem_valid,
	output logic                            mem_ready,
	// DMA address and status
	output logic [video_pkg::ADDR_W-1:0]    dma_addr,
	output logic                            line_done_irq,
	output logic                            band_done_irq,
	output logic                            page_begin_irq
);
	import video_pkg::*;

	// Two-flop synchronisers for the asynchronous pins
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] sync3_reg;
	always_ff @(posedge clock)
	begin
		sync1_reg <= {pixel_clock_input, page_start_strobe_n, line_start_strobe_n}; // [RL20]
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
	end
	logic pclk_rise;
	logic page_fall;
	logic line_fall;
	logic page_active;
	assign pclk_rise   = sync2_reg[2] & ~sync3_reg[2];
	assign page_fall   = ~sync2_reg[1] & sync3_reg[1];
	assign line_fall   = ~sync2_reg[0] & sync3_reg[0];
	assign page_active = ~sync2_reg[1];

	// Video clock tick: every rising input edge in bypass, every eighth in PLL mode
	logic [DIV_W-1:0] div_reg;
	logic             vtick;
	always_ff @(posedge clock)
	begin
		if (rst || (pll_mode && line_fall))
			div_reg <= '0; // [RL4]
		else if (pclk_rise)
			div_reg <= div_reg + 3'h1;
	end
	assign vtick = pclk_rise && (!pll_mode || div_reg == DIV_W'(PLL_DIV - 1)); // [RL5] [RL6]

	// Source selection onto the buffer input
	logic [WORD_W-1:0] in_data;
	logic              in_valid;
	logic              in_ready;
	always_comb
	begin
		case (source_select) // [RL1]
			SRC_LOSSLESS: begin in_data = lossless_data; in_valid = lossless_valid; end
			SRC_ALT:      begin in_data = alt_data;      in_valid = alt_valid;      end
			SRC_DIRECT:   begin in_data = mem_data;      in_valid = mem_valid;      end
			default:      begin in_data = '0;            in_valid = 1'b0;           end
		endcase
	end
	assign lossless_ready = in_ready && source_select == SRC_LOSSLESS;
	assign alt_ready      = in_ready && source_select == SRC_ALT;
	assign mem_ready      = in_ready && source_select == SRC_DIRECT;

	// Two-entry buffer, flip-flop storage indexed by pointers
	logic [WORD_W-1:0] buf_mem [2];
	logic              wr_ptr_reg;
	logic              rd_ptr_reg;
	logic [1:0]        count_reg;
	logic              out_valid;
	logic              out_ready;
	logic              push;
	logic              pop;
	assign in_ready  = count_reg != 2'h2;
	assign out_valid = count_reg != 2'h0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge clock)
	begin
		if (push)
			buf_mem[wr_ptr_reg] <= in_data;
	end
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// DMA address walks up or down one word per accepted word
	always_ff @(posedge clock)
	begin
		if (rst)
			dma_addr <= '0;
		else if (dma_addr_load)
			dma_addr <= dma_start_addr;
		else if (push)
			dma_addr <= dma_address_direction ? dma_addr - ADDR_STEP
			                                  : dma_addr + ADDR_STEP; // [RL8]
	end

	// Margin and shift state machine
	vstate_t             state_reg;
	logic [MARGIN_W-1:0] vcnt_reg;
	logic [MARGIN_W-1:0] hcnt_reg;
	logic [IDX_W-1:0]    bit_reg;
	logic [WORD_W-1:0]   shift_reg;
	logic                shifting;
	logic                vdone_reg;
	logic                hwait_reg;
	logic                line_end_reg;
	assign shifting  = state_reg == ST_SHIFT;
	// Take a word when the margin is spent, or on the last bit unless the line is complete
	assign out_ready = vtick && (state_reg == ST_HSKIP ? (hcnt_reg == '0 && !hwait_reg) :
	                   shifting && bit_reg == IDX_W'(WORD_W - 1) && !line_end_reg); // [RL11]
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			vcnt_reg  <= '0;
			hcnt_reg  <= '0;
			vdone_reg <= 1'b0;
			hwait_reg <= 1'b0;
		end
		else if (page_fall)
		begin
			state_reg <= ST_VSKIP;
			vcnt_reg  <= top_margin_lines; // [RL9] [RL16]
			vdone_reg <= 1'b0;
		end
		else if (line_fall && state_reg != ST_IDLE)
		begin
			if (vdone_reg)
			begin
				state_reg <= ST_HSKIP;
				hcnt_reg  <= left_margin_dots; // [RL10]
				hwait_reg <= 1'b1; // [RL16]
			end
			// Last skipped line: the next strobe starts printing
			else if (vcnt_reg == '0)
				vdone_reg <= 1'b1; // [RL9] [RL16]
			else
				vcnt_reg <= vcnt_reg - 1'b1; // [RL9]
		end
		else if (vtick && state_reg == ST_HSKIP)
		begin
			if (hwait_reg)
				hwait_reg <= 1'b0; // [RL16]
			else if (hcnt_reg != '0)
				hcnt_reg <= hcnt_reg - 1'b1; // [RL10]
			else if (pop)
				state_reg <= ST_SHIFT; // [RL11]
		end
		else if (vtick && shifting && bit_reg == IDX_W'(WORD_W - 1) && !pop)
			state_reg <= ST_VSKIP;
	end

	// Shift register: load on pop, advance one bit per video clock
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			shift_reg <= '0;
			bit_reg   <= '0;
		end
		else if (pop)
		begin
			shift_reg <= buf_mem[rd_ptr_reg]; // [RL3]
			bit_reg   <= '0;
		end
		else if (vtick && shifting)
		begin
			shift_reg <= shift_order_select ? shift_reg >> 1 : shift_reg << 1; // [RL7]
			bit_reg   <= bit_reg + 1'b1;
		end
	end

	// Serial output: current bit, blank when idle, inverted if enabled
	logic pixel_bit;
	assign pixel_bit = shift_order_select ? shift_reg[0] : shift_reg[WORD_W-1];
	always_ff @(posedge clock)
	begin
		if (rst)
			video_out <= 1'b0;
		else
			video_out <= (shifting & pixel_bit) ^ invert_video_enable; // [RL2] [RL12] [RL21]
	end

	// Line and band completion counted on words leaving the buffer
	logic [MARGIN_W-1:0] word_cnt_reg;
	logic [MARGIN_W-1:0] line_cnt_reg;
	logic                last_word;
	assign last_word = pop && word_cnt_reg == words_per_line - 1'b1;
	always_ff @(posedge clock)
	begin
		if (rst || page_fall)
		begin
			word_cnt_reg  <= '0;
			line_cnt_reg  <= '0;
			line_done_irq <= 1'b0;
			band_done_irq <= 1'b0;
		end
		else
		begin
			line_done_irq <= last_word; // [RL17]
			band_done_irq <= last_word && line_cnt_reg == lines_per_band - 1'b1; // [RL18]
			if (last_word)
			begin
				word_cnt_reg <= '0;
				line_cnt_reg <= (line_cnt_reg == lines_per_band - 1'b1) ? '0
				                : line_cnt_reg + 1'b1;
			end
			else if (pop)
				word_cnt_reg <= word_cnt_reg + 1'b1;
		end
	end

	// Line end: no further word is taken until the next line strobe
	always_ff @(posedge clock)
	begin
		if (rst || line_fall)
			line_end_reg <= 1'b0;
		else if (last_word)
			line_end_reg <= 1'b1; // [RL15]
	end

	// Page interrupt follows the synchronised page strobe level
	always_ff @(posedge clock)
	begin
		if (rst)
			page_begin_irq <= 1'b0;
		else
			page_begin_irq <= page_active; // [RL19]
	end

	// Idle output equals the inversion setting one cycle later
	chk_idle_level: assert property (@(posedge clock) disable iff (rst) // [RL21]
		!shifting |=> video_out == $past(invert_video_enable));
	// A popped word enters the shifter
	chk_word_load: assert property (@(posedge clock) disable iff (rst) // [RL3]
		pop |=> shift_reg == $past(buf_mem[rd_ptr_reg]));
	// Buffer never overfills
	chk_buf_bound: assert property (@(posedge clock) disable iff (rst) // [RL1]
		count_reg <= 2'h2);
	// Address moves by one word per push
	chk_addr_step: assert property (@(posedge clock) disable iff (rst) // [RL8]
		push && !dma_addr_load |=> dma_addr == ($past(dma_address_direction)
		? $past(dma_addr) - ADDR_STEP : $past(dma_addr) + ADDR_STEP));
	// Page strobe starts the vertical margin
	chk_page_start: assert property (@(posedge clock) disable iff (rst) // [RL9]
		page_fall |=> state_reg == ST_VSKIP && vcnt_reg == $past(top_margin_lines));
	// Shifting advances bit counter on each tick
	chk_bit_step: assert property (@(posedge clock) disable iff (rst) // [RL2]
		vtick && shifting && !pop && !page_fall |=> bit_reg == $past(bit_reg) + 1'b1);
	// Page interrupt tracks the strobe
	chk_page_irq: assert property (@(posedge clock) disable iff (rst) // [RL19]
		page_active |=> page_begin_irq);
	// Line interrupt follows the last word
	chk_line_irq: assert property (@(posedge clock) disable iff (rst) // [RL17]
		last_word && !page_fall |=> line_done_irq);
endmodule

// ==== video_pkg.sv ====
// Package for the printer video serializer: widths, counts, source codes.
// Assumes a single system clock domain; the pixel clock is sampled as data.
package video_pkg;
	localparam int WORD_W      = 32;
	localparam int IDX_W       = 5;
	localparam int MARGIN_W    = 16;
	localparam int ADDR_W      = 24;
	localparam int PLL_DIV     = 8;
	localparam int DIV_W       = 3;
	localparam int RESET_VCLKS = 5;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000004;
	localparam logic [1:0] SRC_LOSSLESS = 2'h0;
	localparam logic [1:0] SRC_ALT      = 2'h1;
	localparam logic [1:0] SRC_DIRECT   = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_VSKIP = 2'b01,
		ST_HSKIP = 2'b10,
		ST_SHIFT = 2'b11
	} vstate_t;
endpackage

// ==== video_engine_model.sv ====
// Printer engine model: pixel clock, page and line strobes, video sampling.
// Assumes the serializer runs in bypass mode from this pixel clock.
`timescale 1ns/1ps
module video_engine_model
(
	// Engine pins
	output logic        pixel_clock_input,
	output logic        page_start_strobe_n,
	output logic        line_start_strobe_n,
	input  wire logic   video_out,
	// Samples taken after the last strobe
	output logic [47:0] cap
);
	// Engine clock runs free, 160 ns period
	initial pixel_clock_input = 1'b0;
	always #80 pixel_clock_input = ~pixel_clock_input;
	// Strobes idle high
	initial
	begin
		page_start_strobe_n = 1'b1;
		line_start_strobe_n = 1'b1;
		cap = '0;
	end
	// Strobe lasts two pixel periods; video sampled on falling pixel edges
	task automatic pulse(input bit line);
		@(negedge pixel_clock_input);
		if (line)
			line_start_strobe_n = 1'b0;
		else
			page_start_strobe_n = 1'b0;
		for (int i = 0; i < 48; i++)
		begin
			@(negedge pixel_clock_input);
			cap[i] = video_out;
			if (i == 1)
			begin
				line_start_strobe_n = 1'b1;
				page_start_strobe_n = 1'b1;
			end
		end
	endtask
endmodule

// ==== printer_video_serializer_tb.sv ====
// Testbench for the printer video serializer with an engine model.
// Assumes bypass clocking and one word per line.
`timescale 1ns/1ps
module printer_video_serializer_tb;
	import video_pkg::*;
	localparam logic [31:0] WA = 32'hA5C30F81;
	localparam logic [31:0] WB = 32'h9E3779B1;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        order = 1'b0;
	logic        dir = 1'b0;
	logic        inv = 1'b0;
	logic        addr_load = 1'b0;
	logic        pll = 1'b0;
	logic [15:0] top_m = 16'h0001;
	logic [15:0] left_m = 16'h0003;
	logic [23:0] start_a = 24'h000100;
	logic [1:0]  src = 2'h2;
	logic [31:0] dat [3] = '{32'h0, 32'h0, 32'h0};
	logic [2:0]  vld = 3'h0;
	wire  [2:0]  rdy;
	logic        pclk, page_n, line_n, video_out, line_irq, band_irq, page_irq;
	logic [23:0] dma_addr;
	logic [47:0] cap;
	int          err_count, n_compared, n_line, n_band, n_page;
	printer_video_serializer dut (.clock(clock), .rst(rst), .pixel_clock_input(pclk),
		.page_start_strobe_n(page_n), .line_start_strobe_n(line_n), .video_out(video_out),
		.pll_mode(pll), .shift_order_select(order), .dma_address_direction(dir),
		.invert_video_enable(inv), .top_margin_lines(top_m), .left_margin_dots(left_m),
		.words_per_line(16'h0001), .lines_per_band(16'h0004), .dma_start_addr(start_a),
		.dma_addr_load(addr_load), .source_select(src), .lossless_data(dat[0]),
		.lossless_valid(vld[0]), .lossless_ready(rdy[0]), .alt_data(dat[1]),
		.alt_valid(vld[1]), .alt_ready(rdy[1]), .mem_data(dat[2]), .mem_valid(vld[2]),
		.mem_ready(rdy[2]), .dma_addr(dma_addr), .line_done_irq(line_irq),
		.band_done_irq(band_irq), .page_begin_irq(page_irq));
	video_engine_model eng (.pixel_clock_input(pclk), .page_start_strobe_n(page_n),
		.line_start_strobe_n(line_n), .video_out(video_out), .cap(cap));
	// System clock, 100 MHz
	always #5 clock = ~clock;
	// Count interrupt cycles
	always @(posedge clock)
	begin
		n_line += (line_irq === 1'b1);
		n_band += (band_irq === 1'b1);
		n_page += (page_irq === 1'b1);
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Offer one word on the selected source, held until taken
	task automatic push(input logic [31:0] w);
		@(negedge clock);
		dat[src] = w;
		vld[src] = 1'b1;
		for (int k = 0; k < 50; k++)
		begin
			if (rdy[src] === 1'b1)
				break;
			@(negedge clock);
		end
		// Ready seen settled; the rising edge in between takes the word
		@(negedge clock);
		vld[src] = 1'b0;
	endtask
	// One line strobe; judge margin, bit order, polarity and idle level
	task automatic run_line(input logic [31:0] w, input bit data);
		int          idx;
		logic [31:0] got;
		logic [31:0] e;
		eng.pulse(1'b1);
		idx = 48;
		for (int i = 47; i >= 0; i--)
			if (cap[i] !== inv)
				idx = i;
		if (!data)
		begin
			chk("skipped line", idx, 48);
			return;
		end
		chk("margin dots", (idx >= 4) && (idx <= 5), 1);
		e = order ? {<<{w}} : w;
		for (int j = 0; j < 32; j++)
			got[31 - j] = cap[(idx + j) % 48];
		chk("pixel word", got, e ^ {32{inv}});
		chk("trailing idle", cap[(idx + 32) % 48], inv);
	endtask
	task automatic t_reset();
		chk("video idle", video_out, 0);
		chk("irqs", {line_irq, band_irq, page_irq}, 0);
		chk("ready", rdy, 3'h4);
	endtask
	task automatic t_fill();
		@(negedge clock);
		addr_load = 1'b1;
		@(negedge clock);
		addr_load = 1'b0;
		chk("address load", dma_addr, 24'h000100);
		push(WA);
		push(WB);
		chk("address up", dma_addr, 24'h000108);
		chk("buffer full", rdy, 3'h0);
	endtask
	task automatic t_page();
		n_page = 0;
		eng.pulse(1'b0);
		chk("page irq seen", n_page > 0, 1);
		chk("page irq drops", page_irq, 0);
		run_line(WA, 0);
		run_line(WA, 0);
		run_line(WA, 1);
		run_line(WB, 1);
	endtask
	task automatic t_lines();
		@(negedge clock);
		src = 2'h0;
		order = 1'b1;
		inv = 1'b1;
		dir = 1'b1;
		push(WA);
		chk("address down", dma_addr, 24'h000104);
		run_line(WA, 1);
		@(negedge clock);
		src = 2'h1;
		order = 1'b0;
		inv = 1'b0;
		push(WB);
		run_line(WB, 1);
		chk("line irqs", n_line, 4);
		chk("band irqs", n_band, 1);
	endtask
	// Main sequence
	initial
	begin
		// Reset spans more than five video clocks
		repeat (6) @(posedge pclk);
		@(negedge clock);
		rst = 1'b0;
		t_reset();
		t_fill();
		t_page();
		t_lines();
		wrap_up();
	end
	// Watchdog for a hung run
	initial
	begin
		#200us;
		err_count++;
		wrap_up();
	end
endmodule
